// ==== rtl/gcr_pkg.sv ====
// Purpose: Shared constants and types for the global control register bank.
// Assumes: 8-bit register port on mclk at 100 MHz.
// Notes:   Offsets, bit positions, reset values and timing counts live here.
package gcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and offsets.
  localparam int        ADDR_W         = 8;
  localparam int        DATA_W         = 8;
  localparam logic [7:0] OFS_OWN_ADDR  = 8'h00;
  localparam logic [7:0] OFS_SOFT_RST  = 8'h01;
  localparam logic [7:0] OFS_GEN_CFG   = 8'h02;
  localparam logic [7:0] OFS_DEV_STAT  = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_OVR_SEL     = 0;
  localparam int ADDR_LSB        = 1;
  localparam int ADDR_MSB        = 7;
  localparam int ADDR_W7         = 7;
  localparam int BIT_ROM_RELOAD  = 2;
  localparam int BIT_FULL_RST    = 1;
  localparam int BIT_LOGIC_RST   = 0;
  localparam int GEN_CFG_W       = 6;
  localparam int BIT_INIT_DONE   = 6;
  localparam int BIT_REFCLK_OK   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_OWN_ADDR = 8'h00;
  localparam logic [7:0] RST_GEN_CFG  = 8'h1E;
  localparam logic [7:0] RD_ZERO      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Port counts and timing.
  localparam int NUM_RX           = 4;
  localparam int NUM_TX           = 2;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SOFT_RESET_NS    = 100;
  localparam int SOFT_RESET_CYC   = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE_CYC = 4;
  localparam int SETTLE_W         = 3;
  localparam int SYNC_STAGES      = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef struct packed {
    logic ctrl_en;
    logic unlock_policy;
    logic drive_en;
    logic idle_sel;
    logic parity_en;
    logic refclk_ovr;
  } gcr_gen_cfg_t;

  typedef enum logic [1:0] {TX_RUN, TX_HIZ, TX_LP11, TX_HS0} gcr_tx_state_t;

  typedef enum logic [1:0] {LD_IDLE, LD_START, LD_WAIT} gcr_load_state_t;

endpackage

// ==== rtl/gcr_sync3.sv ====
// Purpose: Three-stage synchroniser for pin inputs with agreement filter.
// Assumes: Inputs are asynchronous to mclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module gcr_sync3
  import gcr_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Pin side.
  input  wire logic [W-1:0] pin_in,
  // Core side.
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only when the second and third stages agree, so a
  // metastable resolution on one edge cannot leak out as a glitch.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_out[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule

// ==== rtl/gcr_sc_pulse.sv ====
// Purpose: Self-clearing request timer that holds busy for a fixed span.
// Assumes: start is a one-cycle pulse on mclk.
// Notes:   A start while busy restarts the span.
`timescale 1ns/10ps
module gcr_sc_pulse
  import gcr_pkg::*;
#(
  parameter int CYCLES = SOFT_RESET_CYC
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst_n,
  // Request and status.
  input  wire logic start,
  output logic      busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (start) begin
      count_ff <= LOAD;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - CW'(1);
    end
  end

  assign busy = (count_ff != '0);

endmodule

// ==== rtl/gcr_top.sv ====
// Purpose: Global control register bank: own bus address, soft resets and
//          ROM reload, general configuration and transmit idle state.
// Assumes: Register port on mclk; ROM loader, reset tree, receivers and
//          transmitters sit outside and meet this block on plain signals.
// Notes:   Read data stand one cycle after the read strobe, only there.
//
// Contract
// RULE1 - Address bits 7:1 always read the bus address currently answered.
// RULE2 - Override clear: address field read-only, shows strap latched at startup.
// RULE3 - Override set: address field writable and replaces the strapped address.
// RULE4 - After reset the address default comes from the sampled strap pins.
// RULE5 - Writing one to bit 2 restarts ROM load; self-clears; zero does nothing.
// RULE6 - Software polls initialization-complete to see reload finish.
// RULE7 - Initialization-complete sets only after configuration load has finished.
// RULE8 - Writing one to bit 1 resets all logic and registers; self-clears.
// RULE9 - Writing one to bit 0 resets logic, keeps registers; self-clears.
// RULE10 - Software prefers logic-only reset to keep configuration.
// RULE11 - Bus controller enabled when bit 5 is one; resets to disabled.
// RULE12 - Policy bit 4 zero and no assigned lock: transmit port high impedance.
// RULE13 - Policy one: port under its own control, rests in LP-11 unlocked.
// RULE14 - Idle select one and drive enable zero: transmit outputs high impedance.
// RULE15 - Idle select zero with no lock: transmit outputs driven to HS-0.
// RULE16 - Bit 1, reset one, enables receiver parity checking.
// RULE17 - Bit 0 set forces reference clock present; clear uses detector.
// RULE18 - Self-clearing bits read one while in progress, then zero.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
module gcr_top
  import gcr_pkg::*;
(
  // Clock and reset.
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0]              reg_addr,
  input  wire logic [DATA_W-1:0]              reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [DATA_W-1:0]              reg_rdata,
  // Pins.
  input  wire logic [ADDR_W7-1:0]             strap_addr_pin,
  input  wire logic                           refclk_detect_pin,
  input  wire logic [NUM_RX-1:0]              rx_lock_pin,
  // Same-domain inputs.
  input  wire logic [NUM_TX-1:0][NUM_RX-1:0]  tx_rx_assign,
  input  wire logic                           rom_load_done,
  // Control outputs.
  output logic      [ADDR_W7-1:0]             own_address,
  output logic                                rom_load_start,
  output logic                                logic_reset,
  output logic                                full_reset,
  output logic                                init_done,
  output logic                                i2c_controller_en,
  output logic                                rx_parity_check_en,
  output logic                                refclk_present,
  output gcr_tx_state_t [NUM_TX-1:0]          tx_state
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding.

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic gcr_tx_state_t idle_state(input gcr_gen_cfg_t c, input logic locked);
    if (locked) begin
      idle_state = TX_RUN;
    end else if (!c.unlock_policy) begin
      idle_state = TX_HIZ;                                   // see RULE12
    end else if (c.idle_sel && !c.drive_en) begin
      idle_state = TX_HIZ;                                   // see RULE14
    end else if (!c.idle_sel) begin
      idle_state = TX_HS0;                                   // see RULE15
    end else begin
      idle_state = TX_LP11;                                  // see RULE13
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [ADDR_W7-1:0]  strap_sync;
  logic                refclk_sync;
  logic [NUM_RX-1:0]   lock_sync;
  logic [NUM_TX-1:0]   tx_locked;
  logic [ADDR_W7-1:0]  strap_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic                strap_done_ff;
  logic                ovr_sel_ff;
  logic [ADDR_W7-1:0]  addr_field_ff;
  gcr_gen_cfg_t        gen_cfg_ff;
  gcr_load_state_t     load_state_ff;
  logic                init_done_ff;
  logic                start_ff;
  logic                full_busy;
  logic                logic_busy;
  logic                wr_own;
  logic                wr_soft;
  logic                wr_cfg;
  logic                full_start;
  logic                logic_start;
  logic                reload_req;
  logic [ADDR_W7-1:0]  nxt_own_addr;
  logic [DATA_W-1:0]   nxt_rdata;
  logic [DATA_W-1:0]   rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  gcr_sync3 #(.W(ADDR_W7)) u_strap_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    (strap_addr_pin),
    .level_out (strap_sync)
  );

  gcr_sync3 #(.W(1)) u_refclk_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    (refclk_detect_pin),
    .level_out (refclk_sync)
  );

  gcr_sync3 #(.W(NUM_RX)) u_lock_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .pin_in    (rx_lock_pin),
    .level_out (lock_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes. Register writes are held off while the full reset runs,
  // since the registers themselves are being held at their defaults.
  // Several request bits may be set in one write; each starts its own action.

  assign wr_own      = reg_wr && hit(reg_addr, OFS_OWN_ADDR) && !full_busy;
  assign wr_soft     = reg_wr && hit(reg_addr, OFS_SOFT_RST) && !full_busy;
  assign wr_cfg      = reg_wr && hit(reg_addr, OFS_GEN_CFG) && !full_busy;
  assign full_start  = wr_soft && reg_wdata[BIT_FULL_RST];    // see RULE8
  assign logic_start = wr_soft && reg_wdata[BIT_LOGIC_RST];   // see RULE9
  assign reload_req  = wr_soft && reg_wdata[BIT_ROM_RELOAD];  // see RULE5

  ////////////////////////////////////////////////////////////////////////////
  // Self-clearing soft resets.
  // A second request while a logic reset runs restarts the span, so that reset is
  // stretched by a repeated write but never cut short; a running full reset refuses it.

  gcr_sc_pulse #(.CYCLES(SOFT_RESET_CYC)) u_full_rst (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (full_start),
    .busy  (full_busy)
  );

  gcr_sc_pulse #(.CYCLES(SOFT_RESET_CYC)) u_logic_rst (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (logic_start),
    .busy  (logic_busy)
  );

  assign full_reset  = full_busy;                               // see RULE8
  assign logic_reset = full_busy || logic_busy;                 // see RULE9

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture. The strap is taken once, a few cycles after release, so
  // that the synchroniser has filled; a full soft reset does not retake it.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      settle_ff     <= '0;
      strap_done_ff <= 1'b0;
      strap_ff      <= '0;
    end else if (!strap_done_ff) begin
      if (settle_ff == SETTLE_W'(STRAP_SETTLE_CYC)) begin
        strap_ff      <= strap_sync;                            // see RULE4
        strap_done_ff <= 1'b1;
      end else begin
        settle_ff <= settle_ff + SETTLE_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Own bus address register.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ovr_sel_ff    <= RST_OWN_ADDR[BIT_OVR_SEL];
      addr_field_ff <= RST_OWN_ADDR[ADDR_MSB:ADDR_LSB];
    end else if (full_start) begin
      ovr_sel_ff    <= RST_OWN_ADDR[BIT_OVR_SEL];
      addr_field_ff <= RST_OWN_ADDR[ADDR_MSB:ADDR_LSB];
    end else if (wr_own) begin
      ovr_sel_ff <= reg_wdata[BIT_OVR_SEL];
      if (reg_wdata[BIT_OVR_SEL]) begin
        addr_field_ff <= reg_wdata[ADDR_MSB:ADDR_LSB];          // see RULE3
      end
    end
  end

  // The field written under override is kept when override is dropped, but
  // it is not answered to; the strap is, see RULE2.
  assign nxt_own_addr = ovr_sel_ff ? addr_field_ff : strap_ff; // see RULE2

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      own_address <= '0;
    end else begin
      own_address <= nxt_own_addr;                              // see RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // General configuration register.
  // Bits 7:6 are reserved and not stored, so they always read back as zero.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gen_cfg_ff <= gcr_gen_cfg_t'(RST_GEN_CFG[GEN_CFG_W-1:0]);
    end else if (full_start) begin
      gen_cfg_ff <= gcr_gen_cfg_t'(RST_GEN_CFG[GEN_CFG_W-1:0]); // see RULE8
    end else if (wr_cfg) begin
      gen_cfg_ff <= gcr_gen_cfg_t'(reg_wdata[GEN_CFG_W-1:0]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_controller_en  <= 1'b0;
      rx_parity_check_en <= 1'b0;
      refclk_present     <= 1'b0;
    end else begin
      i2c_controller_en  <= gen_cfg_ff.ctrl_en;                 // see RULE11
      rx_parity_check_en <= gen_cfg_ff.parity_en;               // see RULE16
      refclk_present     <= gen_cfg_ff.refclk_ovr | refclk_sync; // see RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit idle state, one per transmit port.
  // A port counts as locked when any receiver assigned to it is locked. The
  // mask is a same-clock level, so a new assignment acts on the next edge.

  for (genvar t = 0; t < NUM_TX; t++) begin : g_tx
    assign tx_locked[t] = |(tx_rx_assign[t] & lock_sync);          // see RULE12
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        tx_state[t] <= TX_HIZ;
      end else begin
        tx_state[t] <= idle_state(gen_cfg_ff, tx_locked[t]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ROM load sequencer. Loading starts on its own after reset and again on a
  // reload request or a full soft reset. A request while a load runs is
  // absorbed into it, so the flag never drops between two loads.
  // The loader must answer: a done pulse that never comes leaves the flag
  // low for good, which software sees as a load still in progress.

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_state_ff <= LD_START;
    end else begin
      case (load_state_ff)
        LD_IDLE: begin
          if (reload_req || full_start) begin
            load_state_ff <= LD_START;                          // see RULE5
          end
        end
        LD_START: begin
          load_state_ff <= LD_WAIT;
        end
        LD_WAIT: begin
          if (rom_load_done) begin
            load_state_ff <= LD_IDLE;
          end
        end
        default: begin
          load_state_ff <= LD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_ff <= 1'b0;
    end else begin
      start_ff <= (load_state_ff == LD_START);
    end
  end

  assign rom_load_start = start_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_ff <= 1'b0;
    end else if (load_state_ff == LD_WAIT && rom_load_done) begin
      init_done_ff <= 1'b1;                                     // see RULE7
    end else if (load_state_ff == LD_START) begin
      init_done_ff <= 1'b0;                                     // see RULE6
    end
  end

  assign init_done = init_done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Data are registered and held only for the cycle after the
  // strobe; unmapped offsets and reserved bits read as zero.
  // Status is taken at the strobe edge, so a poll shows the state of the
  // cycle in which it was asked, one cycle before the data stand.

  always_comb begin
    nxt_rdata = RD_ZERO;
    if (hit(reg_addr, OFS_OWN_ADDR)) begin
      nxt_rdata[ADDR_MSB:ADDR_LSB] = nxt_own_addr;              // see RULE1
      nxt_rdata[BIT_OVR_SEL]       = ovr_sel_ff;
    end else if (hit(reg_addr, OFS_SOFT_RST)) begin
      nxt_rdata[BIT_ROM_RELOAD] = (load_state_ff != LD_IDLE);   // see RULE18
      nxt_rdata[BIT_FULL_RST]   = full_busy;                    // see RULE18
      nxt_rdata[BIT_LOGIC_RST]  = logic_busy;                   // see RULE18
    end else if (hit(reg_addr, OFS_GEN_CFG)) begin
      nxt_rdata[GEN_CFG_W-1:0] = gen_cfg_ff;
    end else if (hit(reg_addr, OFS_DEV_STAT)) begin
      nxt_rdata[BIT_INIT_DONE] = init_done_ff;                  // see RULE6
      nxt_rdata[BIT_REFCLK_OK] = refclk_present;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= RD_ZERO;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= RD_ZERO;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// ==== testbench/gcr_checker.sv ====
// Purpose: Port assertions for the global control register bank.
// Assumes: One clock domain, mclk, with asynchronous active-low rst_n.
// Notes:   Bound to gcr_top below; watches design ports only.
`timescale 1ns/10ps
module gcr_checker
  import gcr_pkg::*;
(
  // Clock and reset.
  input wire logic                mclk,
  input wire logic                rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  // Control side.
  input wire logic [ADDR_W7-1:0]  own_address,
  input wire logic                rom_load_done,
  input wire logic                rom_load_start,
  input wire logic                logic_reset,
  input wire logic                full_reset,
  input wire logic                init_done,
  input wire logic                i2c_controller_en,
  input wire logic                rx_parity_check_en,
  input wire logic                refclk_present
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Writes that the bank accepts; a running full reset refuses them.
  logic wr_own;
  logic wr_rst;
  logic wr_cfg;
  assign wr_own = reg_wr && reg_addr == OFS_OWN_ADDR && !full_reset;
  assign wr_rst = reg_wr && reg_addr == OFS_SOFT_RST && !full_reset;
  assign wr_cfg = reg_wr && reg_addr == OFS_GEN_CFG && !full_reset;

  sequence full_span;
    full_reset[*8] ##1 full_reset[*2] ##1 !full_reset;
  endsequence
  sequence logic_span;
    logic_reset[*8] ##1 logic_reset[*2] ##1 !logic_reset;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  addr_readback_a: assert property (reg_rd && reg_addr == OFS_OWN_ADDR |=>
    reg_rdata[7:1] == own_address) else $error("address readback differs");
  addr_override_a: assert property (wr_own && reg_wdata[0] |-> ##2
    own_address == $past(reg_wdata[7:1], 2)) else $error("override address not used");
  reload_start_a: assert property (wr_rst && reg_wdata[2] && init_done |->
    ##2 rom_load_start ##1 !rom_load_start) else $error("reload pulse missing");
  reload_zero_a: assert property (wr_rst && reg_wdata[2:0] == 3'h0 && init_done
    |-> ##2 !rom_load_start) else $error("zero write started a reload");
  init_after_load_a: assert property ($rose(init_done) |-> $past(rom_load_done))
    else $error("init done without load done");
  full_span_a: assert property (wr_rst && reg_wdata[1] |=> full_span)
    else $error("full reset span wrong");
  logic_span_a: assert property (wr_rst && reg_wdata[0] && !reg_wdata[1] &&
    !logic_reset |=> logic_span) else $error("logic reset span wrong");
  ctrl_en_copy_a: assert property (wr_cfg |-> ##2
    i2c_controller_en == $past(reg_wdata[5], 2)) else $error("controller enable wrong");
  parity_copy_a: assert property (wr_cfg |-> ##2
    rx_parity_check_en == $past(reg_wdata[1], 2)) else $error("parity enable wrong");
  refclk_force_a: assert property (wr_cfg && reg_wdata[0] |-> ##2 refclk_present)
    else $error("forced reference clock not shown");
endmodule

bind gcr_top gcr_checker u_chk (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .own_address, .rom_load_done, .rom_load_start, .logic_reset, .full_reset,
  .init_done, .i2c_controller_en, .rx_parity_check_en, .refclk_present);

// ==== testbench/global_control_regs_test.sv ====
// Purpose: Self-checking bench for the global control register bank.
// Assumes: Register port driven at rising mclk; reads checked by a monitor.
// Notes:   Outputs are sampled at the falling edge, where they have settled.
`timescale 1ns/10ps
module global_control_regs_test
  import gcr_pkg::*;
;
  localparam logic [6:0] STRAP = 7'h2B;
  logic                  mclk, rst_n, reg_wr, reg_rd, rom_load_done, refclk_detect_pin;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, val;
  logic [6:0]            strap_addr_pin, own_address;
  logic [3:0]            rx_lock_pin;
  logic [1:0][3:0]       tx_rx_assign;
  logic                  rom_load_start, logic_reset, full_reset, init_done, rd_q;
  logic                  i2c_controller_en, rx_parity_check_en, refclk_present;
  gcr_tx_state_t [1:0]   tx_state;
  logic [7:0]            exp_q[$];
  int                    n_fail, num_checks, seed, n_st, n_lr, n_fr;

  gcr_top uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_addr_pin(strap_addr_pin), .refclk_detect_pin(refclk_detect_pin),
    .rx_lock_pin(rx_lock_pin), .tx_rx_assign(tx_rx_assign), .rom_load_done(rom_load_done),
    .own_address(own_address), .rom_load_start(rom_load_start), .logic_reset(logic_reset),
    .full_reset(full_reset), .init_done(init_done), .i2c_controller_en(i2c_controller_en),
    .rx_parity_check_en(rx_parity_check_en), .refclk_present(refclk_present),
    .tx_state(tx_state));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  // One bus cycle per call, so no strobe is assigned twice in a time step.
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic load_done;
    idle(1);
    rom_load_done <= 1'b1;
    idle(1);
    rom_load_done <= 1'b0;
    idle(2);
  endtask
  function automatic logic [7:0] tx_exp(input logic [2:0] m);
    if (!m[2] || (m[0] && !m[1])) return {6'h00, TX_HIZ};
    if (!m[0]) return {6'h00, TX_HS0};
    return {6'h00, TX_LP11};
  endfunction
  task give_verdict;
    $display("comparisons %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe, so each is checked there.
  always @(posedge mclk) rd_q <= reg_rd;
  always @(negedge mclk) begin
    if (rd_q === 1'b1) chk(reg_rdata, exp_q.pop_front());
    n_st += (rom_load_start === 1'b1);
    n_lr += (logic_reset === 1'b1);
    n_fr += (full_reset === 1'b1);
  end

  initial begin
    #100000;
    n_fail++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, rom_load_done, refclk_detect_pin} = 5'h00;
    {reg_addr, reg_wdata, rx_lock_pin} = 20'h00000;
    {n_fail, num_checks, n_st, n_lr, n_fr} = '0;
    strap_addr_pin = STRAP;
    tx_rx_assign = 8'h21;
    seed = 45424;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    idle(12);
    @(negedge mclk) chk1(init_done, 1'b0);
    load_done;
    @(negedge mclk) chk1(init_done, 1'b1);
    chk({1'b0, own_address}, {1'b0, STRAP});
    rd(OFS_GEN_CFG, 8'h1E);
    rd(OFS_SOFT_RST, 8'h00);
    rd(OFS_OWN_ADDR, {STRAP, 1'b0});
    rd(OFS_DEV_STAT, 8'h40);
    rd(8'h07, 8'h00);
    $display("test reset values done");
    wr(OFS_OWN_ADDR, {~STRAP, 1'b0});
    idle(2);
    rd(OFS_OWN_ADDR, {STRAP, 1'b0});
    val = $random(seed);
    wr(OFS_OWN_ADDR, {val[7:1], 1'b1});
    idle(2);
    rd(OFS_OWN_ADDR, {val[7:1], 1'b1});
    @(negedge mclk) chk({1'b0, own_address}, {1'b0, val[7:1]});
    wr(OFS_OWN_ADDR, 8'h00);
    idle(2);
    rd(OFS_OWN_ADDR, {STRAP, 1'b0});
    $display("test own address done");
    for (int k = 0; k < 4; k++) begin
      val = $random(seed) & 8'h3E | k[0];
      wr(OFS_GEN_CFG, val);
      rd(OFS_GEN_CFG, val);
      idle(2);
      @(negedge mclk) chk1(i2c_controller_en, val[5]);
      chk1(rx_parity_check_en, val[1]);
      chk1(refclk_present, val[0]);
    end
    wr(OFS_GEN_CFG, 8'h1E);
    refclk_detect_pin <= 1'b1;
    idle(8);
    @(negedge mclk) chk1(refclk_present, 1'b1);
    rd(OFS_DEV_STAT, 8'h50);
    refclk_detect_pin <= 1'b0;
    $display("test configuration done");
    for (int k = 0; k < 8; k++) begin
      wr(OFS_GEN_CFG, {3'h0, k[2:0], 2'h2});
      idle(3);
      @(negedge mclk) chk({6'h00, tx_state[0]}, tx_exp(k[2:0]));
      chk({6'h00, tx_state[1]}, tx_exp(k[2:0]));
    end
    wr(OFS_GEN_CFG, 8'h02);
    rx_lock_pin <= 4'h1;
    idle(8);
    @(negedge mclk) chk({6'h00, tx_state[0]}, {6'h00, TX_RUN});
    chk({6'h00, tx_state[1]}, {6'h00, TX_HIZ});
    wr(OFS_GEN_CFG, 8'h1E);
    idle(3);
    @(negedge mclk) chk({6'h00, tx_state[1]}, {6'h00, TX_LP11});
    $display("test transmit idle state done");
    n_st = 0;
    wr(OFS_SOFT_RST, 8'h00);
    rx_lock_pin <= 4'h0;
    idle(4);
    @(negedge mclk) chk(n_st[7:0], 8'h00);
    wr(OFS_SOFT_RST, 8'h04);
    rd(OFS_SOFT_RST, 8'h04);
    idle(3);
    @(negedge mclk) chk(n_st[7:0], 8'h01);
    chk1(init_done, 1'b0);
    load_done;
    @(negedge mclk) chk1(init_done, 1'b1);
    rd(OFS_SOFT_RST, 8'h00);
    $display("test rom reload done");
    wr(OFS_GEN_CFG, 8'h2D);
    idle(2);
    {n_lr, n_fr} = '0;
    wr(OFS_SOFT_RST, 8'h01);
    rd(OFS_SOFT_RST, 8'h01);
    idle(14);
    @(negedge mclk) chk(n_lr[7:0], 8'h0A);
    chk(n_fr[7:0], 8'h00);
    rd(OFS_GEN_CFG, 8'h2D);
    rd(OFS_SOFT_RST, 8'h00);
    $display("test logic reset done");
    {n_lr, n_fr, n_st} = '0;
    wr(OFS_SOFT_RST, 8'h02);
    wr(OFS_GEN_CFG, 8'h3F);
    idle(14);
    @(negedge mclk) chk(n_fr[7:0], 8'h0A);
    chk(n_lr[7:0], 8'h0A);
    chk(n_st[7:0], 8'h01);
    rd(OFS_GEN_CFG, 8'h1E);
    rd(OFS_SOFT_RST, 8'h04);
    load_done;
    @(negedge mclk) chk1(init_done, 1'b1);
    chk1(i2c_controller_en, 1'b0);
    $display("test full reset done");
    chk(exp_q.size(), 8'h00);
    give_verdict;
  end
endmodule
